// file: rtl/ssc_pkg.sv
// Constants and types for the standby and conversion control block
package ssc_pkg;

  // Clock and conversion timing
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned CONV_TIME_NS   = 125_000_000;
  localparam int unsigned CONV_CYCLES    = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FAST_RATE_HZ   = 8;
  // Fastest rate code: period of one conversion time, 1 s / FAST_RATE_HZ
  localparam logic [2:0]  RATE_FAST_CODE = 3'h7;

  // Register byte addresses
  localparam logic [7:0]  ADDR_CONFIG    = 8'h00;
  localparam logic [7:0]  ADDR_RATE      = 8'h04;
  localparam logic [7:0]  ADDR_ONESHOT   = 8'h08;
  localparam logic [7:0]  ADDR_STATUS    = 8'h0c;
  localparam logic [7:0]  ADDR_REMOTE    = 8'h10;
  localparam logic [7:0]  ADDR_LOCAL     = 8'h14;

  // Field positions
  localparam int unsigned CFG_RUN_STOP   = 0;
  localparam int unsigned RATE_LSB       = 0;
  localparam int unsigned STAT_BUSY      = 0;
  localparam int unsigned STAT_HW_SBY    = 1;
  localparam int unsigned STAT_SW_SBY    = 2;

  // Reset values
  localparam logic        RUN_STOP_RST   = 1'b0;
  localparam logic [2:0]  RATE_RST       = 3'h5;
  localparam logic [7:0]  TEMP_RST       = 8'h00;

  // Bus responses
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  typedef enum logic [1:0] {
    SSC_IDLE,
    SSC_REMOTE,
    SSC_LOCAL
  } ssc_state_e;

endpackage

// file: rtl/ssc_top.sv
// Standby and conversion sequencing with an AXI4-Lite register slave
//
// Implementation choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps

module ssc_top
  import ssc_pkg::*;
#(
  parameter int unsigned CONV_CYC = CONV_CYCLES
) (
  input  wire logic        MCLK,
  input  wire logic        ARST_N,
  input  wire logic        HW_STANDBY_N,
  input  wire logic [7:0]  ADC_DATA,
  output logic             ADC_EN,
  output logic             ADC_CH_LOCAL,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        WVALID,
  output logic             WREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  output logic             BVALID,
  input  wire logic        BREADY,
  output logic [1:0]       BRESP,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  input  wire logic [7:0]  ARADDR,
  output logic             RVALID,
  input  wire logic        RREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP
);

  localparam logic [31:0] REM_LAST = 32'(CONV_CYC / 2 - 1);
  localparam logic [31:0] LOC_LAST = 32'(CONV_CYC - CONV_CYC / 2 - 1);
  localparam logic [31:0] CONV_LEN = 32'(CONV_CYC);

  logic        hs_meta_q, hs_sync_q;
  logic        run_stop_q;
  logic [2:0]  rate_q;
  logic        aw_have_q, w_have_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic        oneshot_pend_q, auto_pend_q;
  logic [31:0] per_cnt_q, cnt_q, conv_len_q;
  ssc_state_e  state_q, state_d;
  logic [7:0]  rem_shadow_q, remote_q, local_q;
  logic        adc_en_q, adc_loc_q, busy_q;
  logic        hw_sby, wr_en, cfg_wr, rate_wr, one_wr, wr_ok, sw_set, abort, start, done;
  logic        rd_ok;
  logic [31:0] rd_word, period;

  // Only the second stage is read; the first may be metastable
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      hs_meta_q <= 1'b1;
      hs_sync_q <= 1'b1;
    end else begin
      hs_meta_q <= HW_STANDBY_N;
      hs_sync_q <= hs_meta_q;
    end
  end
  assign hw_sby = !hs_sync_q;

  // Write address and data are taken in either order
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      aw_have_q <= 1'b0;
      awready_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (AWVALID && awready_q) begin
      aw_have_q <= 1'b1;
      awready_q <= 1'b0;
      aw_addr_q <= AWADDR;
    end else if (bvalid_q && BREADY) begin
      aw_have_q <= 1'b0;
      awready_q <= 1'b1;
    end else if (!aw_have_q) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      w_have_q <= 1'b0;
      wready_q <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (WVALID && wready_q) begin
      w_have_q <= 1'b1;
      wready_q <= 1'b0;
      wdata_q  <= WDATA;
      wstrb_q  <= WSTRB;
    end else if (bvalid_q && BREADY) begin
      w_have_q <= 1'b0;
      wready_q <= 1'b1;
    end else if (!w_have_q) begin
      wready_q <= 1'b1;
    end
  end

  assign wr_en   = aw_have_q && w_have_q && !bvalid_q;
  always_comb begin
    cfg_wr  = 1'b0;
    rate_wr = 1'b0;
    one_wr  = 1'b0;
    wr_ok   = 1'b1;
    if (aw_addr_q == ADDR_CONFIG) begin
      cfg_wr = wr_en && wstrb_q[0];
    end else if (aw_addr_q == ADDR_RATE) begin
      rate_wr = wr_en && wstrb_q[0];
    end else if (aw_addr_q == ADDR_ONESHOT) begin
      one_wr = wr_en;
    end else if (aw_addr_q == ADDR_STATUS || aw_addr_q == ADDR_REMOTE ||
                 aw_addr_q == ADDR_LOCAL) begin
      wr_ok = 1'b1;
    end else begin
      wr_ok = 1'b0;
    end
  end

  // Read-only registers accept writes silently; unmapped addresses get an error
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_en) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (BREADY) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      run_stop_q <= RUN_STOP_RST;
      rate_q     <= RATE_RST;
    end else begin
      if (cfg_wr) begin
        run_stop_q <= wdata_q[CFG_RUN_STOP];
      end
      if (rate_wr) begin
        rate_q <= wdata_q[RATE_LSB +: 3];
      end
    end
  end

  always_comb begin
    rd_ok   = 1'b1;
    rd_word = 32'h0000_0000;
    if (ARADDR == ADDR_CONFIG) begin
      rd_word[CFG_RUN_STOP] = run_stop_q;
    end else if (ARADDR == ADDR_RATE) begin
      rd_word[RATE_LSB +: 3] = rate_q;
    end else if (ARADDR == ADDR_ONESHOT) begin
      rd_word = 32'h0000_0000;
    end else if (ARADDR == ADDR_STATUS) begin
      rd_word[STAT_BUSY]   = busy_q;
      rd_word[STAT_HW_SBY] = hw_sby;
      rd_word[STAT_SW_SBY] = run_stop_q;
    end else if (ARADDR == ADDR_REMOTE) begin
      rd_word[7:0] = remote_q;
    end else if (ARADDR == ADDR_LOCAL) begin
      rd_word[7:0] = local_q;
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= RESP_OKAY;
    end else if (ARVALID && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_word;
      rresp_q   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && RREADY) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end else if (!rvalid_q) begin
      arready_q <= 1'b1;
    end
  end

  // Rate timer: period is one conversion time shifted left by RATE_FAST_CODE minus the rate code
  assign period = CONV_LEN << (RATE_FAST_CODE - rate_q);
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      per_cnt_q <= 32'h0000_0000;
    end else if (hw_sby || run_stop_q || per_cnt_q >= period - 32'h1) begin
      per_cnt_q <= 32'h0000_0000;
    end else begin
      per_cnt_q <= per_cnt_q + 32'h1;
    end
  end

  // Set wins over the start clear for both pending requests; pin standby blocks both sets
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      auto_pend_q    <= 1'b0;
      oneshot_pend_q <= 1'b0;
    end else begin
      if (!hw_sby && !run_stop_q && per_cnt_q >= period - 32'h1) begin
        auto_pend_q <= 1'b1;
      end else if (start || hw_sby || run_stop_q) begin
        auto_pend_q <= 1'b0;
      end
      if (one_wr && !hw_sby) begin
        oneshot_pend_q <= 1'b1;
      end else if (start || hw_sby) begin
        oneshot_pend_q <= 1'b0;
      end
    end
  end

  // A run/stop set that arrives mid-conversion is the software abort
  assign sw_set = cfg_wr && wdata_q[CFG_RUN_STOP] && !run_stop_q;
  assign abort  = hw_sby || sw_set;

  always_comb begin
    state_d = state_q;
    case (state_q)
      SSC_IDLE: begin
        if (!hw_sby && !sw_set && (oneshot_pend_q || (auto_pend_q && !run_stop_q))) begin
          state_d = SSC_REMOTE;
        end
      end
      SSC_REMOTE: begin
        if (abort) begin
          state_d = SSC_IDLE;
        end else if (cnt_q == REM_LAST) begin
          state_d = SSC_LOCAL;
        end
      end
      SSC_LOCAL: begin
        if (abort || cnt_q == LOC_LAST) begin
          state_d = SSC_IDLE;
        end
      end
      default: state_d = SSC_IDLE;
    endcase
  end
  assign start = (state_q == SSC_IDLE) && (state_d == SSC_REMOTE);
  assign done  = (state_q == SSC_LOCAL) && !abort && (cnt_q == LOC_LAST);

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q    <= SSC_IDLE;
      cnt_q      <= 32'h0000_0000;
      conv_len_q <= 32'h0000_0000;
      adc_en_q   <= 1'b0;
      adc_loc_q  <= 1'b0;
      busy_q     <= 1'b0;
    end else begin
      state_q    <= state_d;
      cnt_q      <= (state_d != state_q) ? 32'h0000_0000 : cnt_q + 32'h1;
      conv_len_q <= (state_q == SSC_IDLE) ? 32'h0000_0000 : conv_len_q + 32'h1;
      adc_en_q   <= (state_d != SSC_IDLE);
      adc_loc_q  <= (state_d == SSC_LOCAL);
      busy_q     <= (state_d != SSC_IDLE);
    end
  end

  // Results move only on a completed cycle; aborts drop the shadow
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rem_shadow_q <= TEMP_RST;
      remote_q     <= TEMP_RST;
      local_q      <= TEMP_RST;
    end else begin
      if (state_q == SSC_REMOTE && !abort && cnt_q == REM_LAST) begin
        rem_shadow_q <= ADC_DATA;
      end
      if (done) begin
        remote_q <= rem_shadow_q;
        local_q  <= ADC_DATA;
      end
    end
  end

  assign ADC_EN       = adc_en_q;
  assign ADC_CH_LOCAL = adc_loc_q;
  assign AWREADY      = awready_q;
  assign WREADY       = wready_q;
  assign BVALID       = bvalid_q;
  assign BRESP        = bresp_q;
  assign ARREADY      = arready_q;
  assign RVALID       = rvalid_q;
  assign RDATA        = rdata_q;
  assign RRESP        = rresp_q;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!ARST_N);

  property p_sby_adc_off;
    hw_sby |=> !ADC_EN;
  endproperty
  a_sby_adc_off: assert property (p_sby_adc_off) else $error("converter on in standby");

  property p_hw_oneshot_ignored;
    (hw_sby && state_q == SSC_IDLE) |=> (state_q == SSC_IDLE) && !oneshot_pend_q;
  endproperty
  a_hw_oneshot_ignored: assert property (p_hw_oneshot_ignored) else $error("pin standby start");

  property p_sw_oneshot_runs;
    (!hw_sby && !sw_set && run_stop_q && oneshot_pend_q && state_q == SSC_IDLE)
      |=> (state_q == SSC_REMOTE) && ADC_EN;
  endproperty
  a_sw_oneshot_runs: assert property (p_sw_oneshot_runs) else $error("one-shot not run");

  property p_abort_now;
    (state_q != SSC_IDLE && abort) |=> (state_q == SSC_IDLE) && !busy_q;
  endproperty
  a_abort_now: assert property (p_abort_now) else $error("conversion not aborted");

  property p_abort_keeps;
    (state_q != SSC_IDLE && abort) |=> $stable(remote_q) && $stable(local_q);
  endproperty
  a_abort_keeps: assert property (p_abort_keeps) else $error("aborted result latched");

  property p_conv_len;
    done |-> (conv_len_q == CONV_LEN - 32'h1);
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

  property p_both_channels;
    (state_q == SSC_REMOTE && !abort) |=> (state_q == SSC_REMOTE || state_q == SSC_LOCAL);
  endproperty
  a_both_channels: assert property (p_both_channels) else $error("local channel skipped");

  property p_busy_flag;
    busy_q == (state_q != SSC_IDLE);
  endproperty
  a_busy_flag: assert property (p_busy_flag) else $error("busy flag wrong");

endmodule // ssc_top

// file: test/ssc_adc_model.sv
// Converter model that answers the block's channel requests
`timescale 1ns/100ps
module ssc_adc_model (
  input  wire logic       clk,
  input  wire logic       en,
  input  wire logic       ch_local,
  input  wire logic [7:0] level,
  output logic      [7:0] data
);
  logic tog_q = 1'b0;

  // Idle output keeps changing so a stale sample never looks valid
  always_ff @(posedge clk) begin
    tog_q <= ~tog_q;
  end

  // Local channel returns the inverse so the two channels differ
  assign data = en ? (ch_local ? ~level : level) : (level ^ {8{tog_q}});
endmodule // ssc_adc_model

// file: test/ssc_top_bench.sv
// Self-checking bench for the standby and conversion control block
`timescale 1ns/100ps
module ssc_top_bench;
  import ssc_pkg::*;
  localparam int CONV = 20;
  localparam logic [41:0] ROWS [7] = '{
    {ADDR_CONFIG, 32'h0, RESP_OKAY}, {ADDR_RATE, 29'h0, RATE_RST, RESP_OKAY},
    {ADDR_ONESHOT, 32'h0, RESP_OKAY}, {ADDR_REMOTE, 24'h0, TEMP_RST, RESP_OKAY},
    {ADDR_LOCAL, 24'h0, TEMP_RST, RESP_OKAY}, {8'h18, 32'h0, RESP_SLVERR},
    {ADDR_STATUS, 29'h0, 3'h2, RESP_OKAY}};
  logic        MCLK, ARST_N, HW_STANDBY_N, ADC_EN, ADC_CH_LOCAL;
  logic [7:0]  ADC_DATA, AWADDR, ARADDR, lvl, old;
  logic        AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic        ARVALID, ARREADY, RVALID, RREADY;
  logic [31:0] WDATA, RDATA, d;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP, r;
  int          cyc, nloc, n_mismatch, comparisons;

  ssc_top #(.CONV_CYC(CONV)) dut (.MCLK(MCLK), .ARST_N(ARST_N), .HW_STANDBY_N(HW_STANDBY_N),
    .ADC_DATA(ADC_DATA), .ADC_EN(ADC_EN), .ADC_CH_LOCAL(ADC_CH_LOCAL), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .AWADDR(AWADDR), .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA),
    .WSTRB(WSTRB), .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .ARADDR(ARADDR), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA),
    .RRESP(RRESP));
  ssc_adc_model adc (.clk(MCLK), .en(ADC_EN), .ch_local(ADC_CH_LOCAL), .level(lvl),
    .data(ADC_DATA));

  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Address and data offered together; each dropped at its own handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic aw, w;
    int n;
    aw = 1'b1;
    w = 1'b1;
    n = 0;
    AWADDR <= a;
    WDATA <= v;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    while ((aw || w) && n < 50) begin
      @(posedge MCLK);
      n++;
      if (aw && AWREADY === 1'b1) begin
        aw = 1'b0;
        AWVALID <= 1'b0;
      end
      if (w && WREADY === 1'b1) begin
        w = 1'b0;
        WVALID <= 1'b0;
      end
    end
    do begin @(posedge MCLK); n++; end while (BVALID !== 1'b1 && n < 50);
    resp = BRESP;
    if (n >= 50) n_mismatch++;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    int n;
    n = 0;
    ARADDR <= a;
    ARVALID <= 1'b1;
    do begin @(posedge MCLK); n++; end while (ARREADY !== 1'b1 && n < 50);
    ARVALID <= 1'b0;
    do begin @(posedge MCLK); n++; end while (RVALID !== 1'b1 && n < 50);
    v = RDATA;
    resp = RRESP;
    if (n >= 50) n_mismatch++;
  endtask

  // Bounded wait for the converter enable to reach a level
  // A wait that must succeed counts a mismatch when it runs out
  task automatic wait_en(input logic v, input int lim, input bit must = 1'b1);
    cyc = 0;
    nloc = 0;
    do begin
      @(posedge MCLK);
      cyc++;
      nloc += int'(ADC_CH_LOCAL === 1'b1);
    end while (ADC_EN !== v && cyc < lim);
    if (must) chk("en_level", {31'h0, v}, {31'h0, ADC_EN});
  endtask

  task automatic results;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #100us;
    n_mismatch++;
    results();
  end

  initial begin
    {ARST_N, HW_STANDBY_N, AWVALID, WVALID, ARVALID, AWADDR, ARADDR, WDATA} = '0;
    {BREADY, RREADY, WSTRB, lvl} = {2'b11, 4'hf, 8'ha5};
    repeat (6) @(posedge MCLK);
    ARST_N <= 1'b1;
    @(posedge MCLK);
    foreach (ROWS[i]) begin
      rd(ROWS[i][41:34], d, r);
      chk("rresp", ROWS[i][1:0], r);
      if (ROWS[i][1:0] === RESP_OKAY) chk("rdata", ROWS[i][33:2], d);
    end
    wr(8'h18, 32'h0, r);
    chk("bresp", RESP_SLVERR, r);
    // Pin standby: one-shot must start nothing
    wr(ADDR_ONESHOT, 32'h1, r);
    wait_en(1'b1, 60, 1'b0);
    chk("en_pin_sby", 60, cyc);
    wr(ADDR_CONFIG, 32'h1, r);
    HW_STANDBY_N <= 1'b1;
    wait_en(1'b1, 60, 1'b0);
    chk("en_sw_sby", 60, cyc);
    rd(ADDR_STATUS, d, r);
    chk("status_sw", 32'h4, d);
    wr(ADDR_RATE, 32'h7, r);
    rd(ADDR_RATE, d, r);
    chk("rate", 32'h7, d);
    // Without strobe bit 0 the rate write must be ignored
    WSTRB <= 4'he;
    wr(ADDR_RATE, 32'h3, r);
    WSTRB <= 4'hf;
    rd(ADDR_RATE, d, r);
    chk("rate_strb", 32'h7, d);
    // Software standby: one-shot runs one full cycle
    wr(ADDR_ONESHOT, 32'h1, r);
    wait_en(1'b1, 20);
    wait_en(1'b0, 100);
    chk("conv_len", CONV, cyc);
    chk("local_len", CONV / 2, nloc);
    rd(ADDR_REMOTE, d, r);
    chk("remote", {24'h0, lvl}, d);
    rd(ADDR_LOCAL, d, r);
    chk("local", {24'h0, ~lvl}, d);
    old = lvl;
    lvl <= 8'h3c;
    wr(ADDR_ONESHOT, 32'h1, r);
    wait_en(1'b1, 20);
    rd(ADDR_STATUS, d, r);
    chk("busy", 32'h1, {31'h0, d[STAT_BUSY]});
    rd(ADDR_REMOTE, d, r);
    chk("remote_old", {24'h0, old}, d);
    wait_en(1'b0, 100);
    rd(ADDR_REMOTE, d, r);
    chk("remote_new", 32'h3c, d);
    // Pin abort in mid-conversion keeps earlier results
    lvl <= 8'h77;
    wr(ADDR_ONESHOT, 32'h1, r);
    wait_en(1'b1, 20);
    repeat (3) @(posedge MCLK);
    HW_STANDBY_N <= 1'b0;
    wait_en(1'b0, 10);
    chk("hw_abort", 32'h1, {31'h0, cyc <= 6});
    rd(ADDR_LOCAL, d, r);
    chk("local_kept", 32'hc3, d);
    // Software abort of an automatic conversion
    wr(ADDR_CONFIG, 32'h0, r);
    HW_STANDBY_N <= 1'b1;
    wait_en(1'b1, 100);
    repeat (3) @(posedge MCLK);
    wr(ADDR_CONFIG, 32'h1, r);
    wait_en(1'b0, 10);
    chk("sw_abort", 32'h1, {31'h0, cyc <= 3});
    rd(ADDR_REMOTE, d, r);
    chk("remote_kept", 32'h3c, d);
    // Fastest rate keeps the converter nearly always busy
    wr(ADDR_CONFIG, 32'h0, r);
    cyc = 0;
    repeat (200) begin
      @(posedge MCLK);
      cyc += int'(ADC_EN === 1'b1);
    end
    chk("fast_rate", 32'h1, {31'h0, cyc >= 150});
    // Reset in mid-run stops the converter at once and clears the results
    ARST_N <= 1'b0;
    @(posedge MCLK);
    chk("rst_en", 32'h0, {31'h0, ADC_EN});
    repeat (5) @(posedge MCLK);
    ARST_N <= 1'b1;
    @(posedge MCLK);
    rd(ADDR_REMOTE, d, r);
    chk("rst_remote", {24'h0, TEMP_RST}, d);
    rd(ADDR_CONFIG, d, r);
    chk("rst_cfg", {31'h0, RUN_STOP_RST}, d);
    results();
  end
endmodule // ssc_top_bench
